// *** hw/sfps_seq.sv ***
// Stack frame push/pop sequencer with APB control registers
`timescale 1ns/100ps
`include "sfps_cfg.svh"
module sfps_seq
  import sfps_pkg::*;
#(
  parameter int XLEN = 32,
  parameter int POST_DEPTH = 8,
  parameter logic [31:0] CAUSE_ILLEGAL = 32'h00000002,
  parameter logic [31:0] CAUSE_LOAD_FAULT = 32'h00000005,
  parameter logic [31:0] CAUSE_STORE_FAULT = 32'h00000007,
  parameter bit TVAL_ZERO = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire sfps_op_t instr_op,
  input wire logic [15:0] instr_bits,
  input wire logic [31:0] instr_pc,
  input wire logic [31:0] sp_cur,
  input wire logic mem_idempotent,
  output logic [4:0] rf_raddr,
  input wire logic [31:0] rf_rdata,
  output logic rf_we,
  output logic [4:0] rf_waddr,
  output logic [31:0] rf_wdata,
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output sfps_mem_req_t mem_req,
  input wire logic mem_rsp_valid,
  input wire sfps_mem_rsp_t mem_rsp,
  input wire logic irq_pending,
  output logic irq_hold,
  output logic trap_valid,
  output sfps_trap_t trap,
  output logic commit_valid,
  output sfps_commit_t commit,
  output logic imprecise_err
);

  if (XLEN != 32 || POST_DEPTH < 1 || POST_DEPTH > 15) begin : g_bad_cfg
    $error("sfps_seq: XLEN must be 32 and POST_DEPTH 1..15");
  end

  localparam logic [3:0] POST_MAX = 4'(POST_DEPTH);
  // Minimum frame bytes covering the register list
  function automatic logic [7:0] sfps_adj_base(input logic [3:0] rl);
    logic [7:0] b;
    b = `SFPS_BASE_4;
    if (rl < 4'h8) begin
      b = `SFPS_BASE_1;
    end else if (rl < 4'hC) begin
      b = `SFPS_BASE_2;
    end else if (rl < `SFPS_RLIST_ALL) begin
      b = `SFPS_BASE_3;
    end
    return b;
  endfunction : sfps_adj_base

  sfps_state_t state_r;
  sfps_state_t state_nxt;
  sfps_op_t op_r;
  logic [31:0] pc_r;
  logic [31:0] sp_r;
  logic [7:0] adj_r;
  logic [3:0] slot_r;
  logic [7:0] off_r;
  sfps_mem_req_t req_r;
  sfps_trap_t trap_r;
  sfps_trap_t trap_nxt;
  sfps_commit_t commit_r;
  logic [3:0] post_cnt_r;
  logic [1:0] ctrl_r;
  logic impr_r;
  logic impr_pulse_r;
  logic [31:0] done_cnt_r;
  logic [31:0] prdata_r;
  logic rf_we_r;
  logic [4:0] rf_waddr_r;
  logic [31:0] rf_wdata_r;

  wire [3:0] rlist = instr_bits[`SFPS_RLIST_MSB:`SFPS_RLIST_LSB];
  wire [1:0] spimm = instr_bits[`SFPS_SPIMM_MSB:`SFPS_SPIMM_LSB];
  wire start = (state_r == ST_IDLE) && instr_valid;
  // Lists below ra or ending at s10 have no code
  wire rlist_ok = rlist >= `SFPS_RLIST_MIN;
  wire [3:0] n_dec = (rlist == `SFPS_RLIST_ALL) ? `SFPS_SLOTS_ALL : (rlist - `SFPS_RLIST_BIAS);
  wire [7:0] adj_dec = sfps_adj_base(rlist) + (8'(spimm) * `SFPS_FRAME_STEP);
  wire start_create = instr_op == SFPS_FRAME_CREATE;
  wire [31:0] start_top = start_create ? sp_cur : (sp_cur + {24'h0, adj_dec});
  wire [31:0] first_addr = start_top - {24'h0, `SFPS_WORD_BYTES};

  wire is_create = op_r == SFPS_FRAME_CREATE;
  wire [31:0] top = is_create ? sp_r : (sp_r + {24'h0, adj_r});
  wire [31:0] cur_addr = top - {24'h0, off_r};
  wire last_slot = slot_r == 4'h0;
  wire posted_mode = ctrl_r[`SFPS_CTRL_POST_BIT] && is_create;
  wire post_full = post_cnt_r == POST_MAX;
  wire req_fire = mem_req_valid && mem_req_ready;
  wire rsp_posted = mem_rsp_valid && (post_cnt_r != 4'h0);
  wire rsp_own = mem_rsp_valid && (post_cnt_r == 4'h0) && (state_r == ST_RSP);
  wire rsp_ok = rsp_own && !mem_rsp.err;
  wire advance = (req_fire && posted_mode) || rsp_ok;
  // Interrupts abort only between accesses, when enabled
  wire irq_abort = ctrl_r[`SFPS_CTRL_IRQ_BIT] && irq_pending &&
                   ((state_r == ST_MAP) || (state_r == ST_PREP));

  wire apb_wr = psel && penable && pwrite;
  wire apb_setup = psel && !penable;
  wire hit_ctrl = paddr == `SFPS_OFF_CTRL;
  wire hit_status = paddr == `SFPS_OFF_STATUS;
  wire hit_trap = paddr == `SFPS_OFF_TRAP;
  wire hit_done = paddr == `SFPS_OFF_DONE;
  wire hit_any = hit_ctrl || hit_status || hit_trap || hit_done;
  wire impr_clr = apb_wr && hit_status && pwdata[`SFPS_STAT_IMPR_BIT];
  wire [31:0] status_word = {20'h0, slot_r, 6'h0, impr_r, state_r != ST_IDLE};
  wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_r} :
                       hit_status ? status_word :
                       hit_trap ? trap_r.cause :
                       hit_done ? done_cnt_r : 32'h0;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (instr_valid) begin
          state_nxt = (rlist_ok && mem_idempotent) ? ST_MAP : ST_TRAP;
        end
      end
      ST_MAP: begin
        state_nxt = irq_abort ? ST_TRAP : ST_PREP;
      end
      ST_PREP: begin
        state_nxt = irq_abort ? ST_TRAP : ST_REQ;
      end
      ST_REQ: begin
        if (req_fire) begin
          // Posted stores do not wait for bus answers
          state_nxt = !posted_mode ? ST_RSP : (last_slot ? ST_COMMIT : ST_MAP);
        end
      end
      ST_RSP: begin
        if (rsp_own) begin
          // Final stage only after every access succeeded
          state_nxt = mem_rsp.err ? ST_TRAP : (last_slot ? ST_COMMIT : ST_MAP);
        end
      end
      ST_COMMIT: begin
        state_nxt = ST_IDLE;
      end
      ST_TRAP: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Trap reports the stack instruction pc and cause
  always_comb begin
    trap_nxt = trap_r;
    if (start && !(rlist_ok && mem_idempotent)) begin
      trap_nxt.is_irq = 1'b0;
      trap_nxt.epc = instr_pc;
      // Non-idempotent stack faults before any access
      trap_nxt.cause = !rlist_ok ? CAUSE_ILLEGAL :
                       (start_create ? CAUSE_STORE_FAULT : CAUSE_LOAD_FAULT);
      // Faulting address unless tval is hardwired zero
      trap_nxt.tval_we = rlist_ok && !TVAL_ZERO;
      trap_nxt.tval = (rlist_ok && !TVAL_ZERO) ? first_addr : 32'h0;
    end else if (irq_abort) begin
      trap_nxt.is_irq = 1'b1;
      trap_nxt.epc = pc_r;
      trap_nxt.cause = 32'h0;
      trap_nxt.tval_we = 1'b0;
      trap_nxt.tval = 32'h0;
    end else if (rsp_own && mem_rsp.err) begin
      trap_nxt.is_irq = 1'b0;
      trap_nxt.epc = pc_r;
      trap_nxt.cause = is_create ? CAUSE_STORE_FAULT : CAUSE_LOAD_FAULT;
      trap_nxt.tval_we = !TVAL_ZERO;
      trap_nxt.tval = TVAL_ZERO ? 32'h0 : req_r.addr;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      trap_r <= '0;
    end else begin
      state_r <= state_nxt;
      trap_r <= trap_nxt;
    end
  end

  // Instruction context captured when the sequence starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= SFPS_FRAME_CREATE;
      pc_r <= 32'h0;
      sp_r <= 32'h0;
      adj_r <= 8'h00;
    end else if (start) begin
      op_r <= instr_op;
      pc_r <= instr_pc;
      sp_r <= sp_cur;
      adj_r <= adj_dec;
    end
  end

  // Slots run from the top of the frame downward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_r <= 4'h0;
      off_r <= 8'h00;
    end else if (start) begin
      slot_r <= n_dec - 4'h1;
      off_r <= `SFPS_WORD_BYTES;
    end else if (advance && !last_slot) begin
      slot_r <= slot_r - 4'h1;
      off_r <= off_r + `SFPS_WORD_BYTES;
    end
  end

  sfps_slot_map u_map (
    .pclk(pclk),
    .presetn(presetn),
    .slot(slot_r),
    .reg_num(rf_raddr)
  );

  // Store request carries the listed register below sp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= '0;
    end else if (state_r == ST_PREP) begin
      req_r.we <= is_create;
      req_r.addr <= cur_addr;
      req_r.wdata <= is_create ? rf_rdata : 32'h0;
    end
  end

  // Loaded words go straight to the register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_we_r <= 1'b0;
      rf_waddr_r <= 5'h00;
      rf_wdata_r <= 32'h0;
    end else begin
      rf_we_r <= rsp_ok && !is_create;
      rf_waddr_r <= rf_raddr;
      rf_wdata_r <= mem_rsp.rdata;
    end
  end

  // Single sp update after all stores
  // a0, sp and return committed together at the end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      commit_r <= '0;
    end else if (state_nxt == ST_COMMIT && state_r != ST_COMMIT) begin
      // Frame covers the whole register area
      commit_r.sp_val <= is_create ? (sp_r - {24'h0, adj_r}) : (sp_r + {24'h0, adj_r});
      commit_r.a0_zero <= op_r == SFPS_FRAME_DESTROY_RETURN_ZERO;
      // Return target is the restored ra
      // Return rides in the same commit as sp
      commit_r.jump <= (op_r == SFPS_FRAME_DESTROY_RETURN) ||
                       (op_r == SFPS_FRAME_DESTROY_RETURN_ZERO);
      commit_r.target <= is_create ? 32'h0 : mem_rsp.rdata;
    end
  end

  // Outstanding posted stores; answers return in order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_cnt_r <= 4'h0;
    end else if ((req_fire && posted_mode) && !rsp_posted) begin
      post_cnt_r <= post_cnt_r + 4'h1;
    end else if (!(req_fire && posted_mode) && rsp_posted) begin
      post_cnt_r <= post_cnt_r - 4'h1;
    end
  end

  // Late store errors are sticky; set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      impr_r <= 1'b0;
      impr_pulse_r <= 1'b0;
    end else begin
      impr_r <= (rsp_posted && mem_rsp.err) || (impr_r && !impr_clr);
      impr_pulse_r <= rsp_posted && mem_rsp.err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `SFPS_CTRL_RST;
      done_cnt_r <= 32'h0;
      prdata_r <= 32'h0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        ctrl_r <= pwdata[1:0];
      end
      if (state_r == ST_COMMIT) begin
        done_cnt_r <= done_cnt_r + 32'h1;
      end
      if (apb_setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign instr_ready = state_r == ST_IDLE;
  assign rf_we = rf_we_r;
  assign rf_waddr = rf_waddr_r;
  assign rf_wdata = rf_wdata_r;
  assign mem_req_valid = (state_r == ST_REQ) && !(posted_mode && post_full);
  assign mem_req = req_r;
  assign irq_hold = (state_r != ST_IDLE) && !ctrl_r[`SFPS_CTRL_IRQ_BIT];
  // Trap returns to idle; the core refetches and restarts
  assign trap_valid = state_r == ST_TRAP;
  assign trap = trap_r;
  assign commit_valid = state_r == ST_COMMIT;
  assign commit = commit_r;
  assign imprecise_err = impr_pulse_r;
endmodule : sfps_seq

// *** hw/sfps_cfg.svh ***
// Constants for the stack frame push/pop sequencer
// Function
// - Frame create stores listed registers, lowers sp
// - Frame destroy loads listed registers, raises sp
// - Zeroing return variant also clears a0
// - Return variants jump to restored ra
// - Sp moves at least the register area
// - Extra field adds 16-byte steps
// - No list ending at s10; s11 needed
// - After a trap the sequence restarts whole
// - Trap records instruction pc and cause
// - Access fault records address unless tval zero
// - Interrupt policy during sequence is set by CTRL bit 0
// - Stores may come in any order
// - Create looks like stores then sp update
// - Create sp update only once completion certain; with CTRL bit 1 set, sp commits when the last store issues, before its answer
// - Imprecise store errors: wait or report later
// - Destroy commits a0, sp, return atomically
// - Committed sp update implies the return
// - Non-idempotent stack raises load/store access fault
// - Adjust equals base plus field times 16
`ifndef SFPS_CFG_SVH
`define SFPS_CFG_SVH

`define SFPS_OFF_CTRL 12'h000
`define SFPS_OFF_STATUS 12'h004
`define SFPS_OFF_TRAP 12'h008
`define SFPS_OFF_DONE 12'h00C

`define SFPS_CTRL_IRQ_BIT 0
`define SFPS_CTRL_POST_BIT 1
`define SFPS_CTRL_RST 2'h0
`define SFPS_STAT_BUSY_BIT 0
`define SFPS_STAT_IMPR_BIT 1
`define SFPS_STAT_SLOT_LSB 8

`define SFPS_RLIST_MSB 7
`define SFPS_RLIST_LSB 4
`define SFPS_SPIMM_MSB 3
`define SFPS_SPIMM_LSB 2
`define SFPS_RLIST_MIN 4'h4
`define SFPS_RLIST_ALL 4'hF
`define SFPS_SLOTS_ALL 4'hD
`define SFPS_RLIST_BIAS 4'h3

`define SFPS_BASE_1 8'h10
`define SFPS_BASE_2 8'h20
`define SFPS_BASE_3 8'h30
`define SFPS_BASE_4 8'h40
`define SFPS_FRAME_STEP 8'h10
`define SFPS_WORD_BYTES 8'h04

`define SFPS_REG_RA 5'h01
`define SFPS_REG_S0 5'h08
`define SFPS_REG_S2_BIAS 5'h0F

`endif

// *** hw/sfps_pkg.sv ***
// Types shared by the stack frame push/pop sequencer
package sfps_pkg;

  typedef enum logic [1:0] {
    SFPS_FRAME_CREATE,
    SFPS_FRAME_DESTROY,
    SFPS_FRAME_DESTROY_RETURN,
    SFPS_FRAME_DESTROY_RETURN_ZERO
  } sfps_op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MAP,
    ST_PREP,
    ST_REQ,
    ST_RSP,
    ST_COMMIT,
    ST_TRAP
  } sfps_state_t;

  typedef struct packed {
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sfps_mem_req_t;

  typedef struct packed {
    logic err;
    logic [31:0] rdata;
  } sfps_mem_rsp_t;

  typedef struct packed {
    logic is_irq;
    logic [31:0] cause;
    logic [31:0] epc;
    logic tval_we;
    logic [31:0] tval;
  } sfps_trap_t;

  typedef struct packed {
    logic [31:0] sp_val;
    logic a0_zero;
    logic jump;
    logic [31:0] target;
  } sfps_commit_t;

endpackage : sfps_pkg

// *** hw/sfps_slot_map.sv ***
// Registered map from sequence slot to register number
`timescale 1ns/100ps
`include "sfps_cfg.svh"
module sfps_slot_map (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] slot,
  output logic [4:0] reg_num
);

  logic [4:0] reg_num_r;
  logic [4:0] reg_num_nxt;

  // Slot 0 is ra, 1..2 are s0..s1, 3 and up are s2..s11
  assign reg_num_nxt = (slot == 4'h0) ? `SFPS_REG_RA :
                       (slot < 4'h3) ? (`SFPS_REG_S0 + {1'b0, slot} - 5'h01) :
                       (`SFPS_REG_S2_BIAS + {1'b0, slot});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_num_r <= 5'h00;
    end else begin
      reg_num_r <= reg_num_nxt;
    end
  end

  assign reg_num = reg_num_r;

endmodule : sfps_slot_map

// *** test/sfps_seq_checker.sv ***
// Port assertions for the stack frame sequencer
`timescale 1ns/100ps
module sfps_seq_checker
  import sfps_pkg::*;
#(
  parameter logic [31:0] CAUSE_ILLEGAL = 32'h00000002
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [15:0] instr_bits,
  input wire logic [31:0] instr_pc,
  input wire logic mem_idempotent,
  input wire logic mem_req_valid,
  input wire logic mem_req_ready,
  input wire sfps_mem_req_t mem_req,
  input wire logic irq_hold,
  input wire logic trap_valid,
  input wire sfps_trap_t trap,
  input wire logic commit_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic ok_list;
  assign acc = instr_valid && instr_ready;
  assign ok_list = instr_bits[7:4] >= 4'h4;
  illegal_list_a: assert property (acc && !ok_list && mem_idempotent |=>
    trap_valid && trap.cause == CAUSE_ILLEGAL && !trap.tval_we) else $error("no illegal trap");
  fault_epc_a: assert property (acc && !mem_idempotent |=>
    trap_valid && trap.epc == $past(instr_pc)) else $error("bad fault trap");
  trap_pulse_a: assert property (trap_valid |=> !trap_valid && instr_ready)
    else $error("trap pulse");
  commit_pulse_a: assert property (commit_valid |=> !commit_valid && instr_ready)
    else $error("commit pulse");
  trap_excl_a: assert property (trap_valid |-> !commit_valid)
    else $error("trap with commit");
  req_hold_a: assert property (mem_req_valid && !mem_req_ready |=>
    mem_req_valid && $stable(mem_req)) else $error("request dropped");
  accept_busy_a: assert property (acc && ok_list && mem_idempotent |=>
    !instr_ready [*2]) else $error("idle too soon");
  hold_busy_a: assert property (irq_hold |->
    !instr_ready && !(trap_valid && trap.is_irq)) else $error("hold while idle");
  irq_trap_a: assert property (trap_valid && trap.is_irq |->
    trap.cause == 32'h0 && !$past(mem_req_valid)) else $error("bad interrupt trap");
endmodule : sfps_seq_checker

bind sfps_seq sfps_seq_checker #(.CAUSE_ILLEGAL(CAUSE_ILLEGAL)) u_chk (.pclk, .presetn,
  .instr_valid, .instr_ready, .instr_bits, .instr_pc, .mem_idempotent, .mem_req_valid,
  .mem_req_ready, .mem_req, .irq_hold, .trap_valid, .trap, .commit_valid);

// *** test/sfps_mem_model.sv ***
// Behavioural stack memory behind the sequencer
`timescale 1ns/100ps
module sfps_mem_model
  import sfps_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [31:0] err_addr,
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire sfps_mem_req_t mem_req,
  output logic mem_rsp_valid,
  output sfps_mem_rsp_t mem_rsp
);
  logic busy_r;
  logic tick_r;
  logic [1:0] wait_r;
  sfps_mem_req_t pend_r;
  assign mem_req_ready = !busy_r && !(slow && tick_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'h0;
      tick_r <= 1'h0;
      wait_r <= 2'h0;
      pend_r <= '0;
      mem_rsp_valid <= 1'h0;
      mem_rsp <= '0;
    end else begin
      tick_r <= !tick_r;
      mem_rsp_valid <= 1'h0;
      // Idle answer lines change every cycle
      mem_rsp <= ~mem_rsp;
      if (mem_req_valid && mem_req_ready) begin
        busy_r <= 1'h1;
        pend_r <= mem_req;
        wait_r <= slow ? 2'h3 : 2'h0;
      end else if (busy_r && wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end else if (busy_r) begin
        busy_r <= 1'h0;
        mem_rsp_valid <= 1'h1;
        mem_rsp.rdata <= pend_r.addr ^ 32'h5A5A0000;
        mem_rsp.err <= pend_r.addr == err_addr;
      end
    end
  end
endmodule : sfps_mem_model

// *** test/test_stack_frame_push_pop_sequencer.sv ***
// Self-checking bench for the stack frame sequencer
`timescale 1ns/100ps
module test_stack_frame_push_pop_sequencer import sfps_pkg::*;;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, instr_valid = '0;
  logic mem_idempotent = '1, irq_pending = '0, pready, pslverr, instr_ready, rf_we;
  logic mem_req_valid, mem_req_ready, mem_rsp_valid, irq_hold, trap_valid, commit_valid;
  logic imprecise_err, erv, hold_seen, imp_seen = 1'h0;
  logic [11:0] paddr = '0;
  logic [15:0] instr_bits = '0;
  logic [31:0] pwdata = '0, instr_pc = '0, sp_cur = '0, err_addr = 32'h00000001;
  logic [31:0] seed = 32'h0000511C, prdata, rf_rdata, rf_wdata, rdv, top, x, y;
  logic [4:0] rf_raddr, rf_waddr;
  sfps_op_t instr_op = SFPS_FRAME_CREATE;
  sfps_mem_req_t mem_req;
  sfps_mem_rsp_t mem_rsp;
  sfps_trap_t trap, tr;
  sfps_commit_t commit;
  int err_count = 0, num_checks = 0, cyc = 0, ndone = 0, res;

  sfps_seq dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .instr_valid, .instr_ready, .instr_op, .instr_bits, .instr_pc, .sp_cur,
    .mem_idempotent, .rf_raddr, .rf_rdata, .rf_we, .rf_waddr, .rf_wdata, .mem_req_valid,
    .mem_req_ready, .mem_req, .mem_rsp_valid, .mem_rsp, .irq_pending, .irq_hold, .trap_valid,
    .trap, .commit_valid, .commit, .imprecise_err);
  sfps_mem_model u_mem (.pclk, .presetn, .slow(instr_pc[2]), .err_addr, .mem_req_valid,
    .mem_req_ready, .mem_req, .mem_rsp_valid, .mem_rsp);

  always #2 pclk = ~pclk;
  assign rf_rdata = 32'hC0DE0000 | {27'h0, rf_raddr};

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [4:0] sreg(int k);
    return k == 0 ? 5'h01 : k < 3 ? 5'(7 + k) : 5'(15 + k);
  endfunction : sreg
  function automatic logic [31:0] adj(logic [3:0] rl, logic [1:0] si);
    return (rl == 4'hF ? 32'h40 : rl > 4'hB ? 32'h30 : rl > 4'h7 ? 32'h20 : 32'h10)
      + 32'(si) * 32'h10;
  endfunction : adj

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic run(input sfps_op_t op, input logic [3:0] rl, input logic [1:0] si,
                     input logic [31:0] sp, input logic [31:0] pc, input logic idem);
    int n;
    int k;
    logic [4:0] q_r[$];
    logic [31:0] q_a[$];
    n = rl == 4'hF ? 13 : int'(rl) - 3;
    k = n - 1;
    top = op == SFPS_FRAME_CREATE ? sp : sp + adj(rl, si);
    res = 0;
    hold_seen = 1'h0;
    @(posedge pclk);
    instr_op <= op;
    instr_bits <= {8'h00, rl, si, 2'h0};
    sp_cur <= sp;
    instr_pc <= pc;
    mem_idempotent <= idem;
    instr_valid <= 1'h1;
    @(posedge pclk);
    instr_valid <= 1'h0;
    repeat (300) begin
      @(negedge pclk);
      hold_seen |= irq_hold;
      imp_seen |= imprecise_err;
      if (mem_req_valid && mem_req_ready) begin
        chk(mem_req.addr, top - 32'(4 * (n - k)));
        chk(32'(mem_req.we), 32'(op == SFPS_FRAME_CREATE));
        if (mem_req.we) chk(mem_req.wdata, 32'hC0DE0000 | sreg(k));
        else q_r.push_back(sreg(k));
        q_a.push_back(mem_req.addr);
        k--;
      end
      if (rf_we) begin
        chk(32'(q_r.size() > 0), 32'h1);
        if (q_r.size() > 0) chk(32'(rf_waddr), 32'(q_r.pop_front()));
        if (q_a.size() > 0) chk(rf_wdata, q_a.pop_front() ^ 32'h5A5A0000);
      end
      if (trap_valid) begin
        tr = trap;
        res = 1;
        break;
      end
      if (commit_valid) begin
        res = 2;
        ndone++;
        chk(32'(k + 1), 32'h0);
        chk(commit.sp_val, op == SFPS_FRAME_CREATE ? sp - adj(rl, si) : top);
        chk(32'(commit.a0_zero), 32'(op == SFPS_FRAME_DESTROY_RETURN_ZERO));
        chk(32'(commit.jump), 32'(op[1]));
        if (op[1]) chk(commit.target, (top - 32'(4 * n)) ^ 32'h5A5A0000);
        break;
      end
    end
  endtask : run

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      apb(1'h0, 12'(4 * i), 32'h0);
      chk(rdv, 32'h0);
      chk(32'(erv), 32'(i == 4));
    end
    apb(1'h1, 12'h008, 32'hFFFFFFFF);
    apb(1'h0, 12'h008, 32'h0);
    chk(rdv, 32'h0);
    for (int i = 0; i < 40; i++) begin
      x = rnd();
      y = rnd();
      run(sfps_op_t'(i < 8 ? i % 4 : x[1:0]), i < 4 ? 4'h4 : i < 8 ? 4'hF : 4'(4 + x[5:2] % 12),
          x[7:6], {y[31:4], 4'h0}, {x[31:1], 1'h0}, 1'h1);
      chk(32'(res), 32'h2);
    end
    for (int i = 0; i < 8; i++) begin
      x = rnd();
      run(sfps_op_t'(i % 4), i < 4 ? 4'(i) : 4'h6, 2'h1, 32'h00008000, x, i < 4);
      chk(32'(res), 32'h1);
      chk(tr.epc, x);
      chk(tr.cause, i < 4 ? 32'h2 : i == 4 ? 32'h7 : 32'h5);
      chk(32'(tr.tval_we), 32'(i >= 4));
      if (i >= 4) chk(tr.tval, top - 32'h4);
    end
    apb(1'h1, 12'h000, 32'h1);
    irq_pending <= 1'h1;
    run(SFPS_FRAME_DESTROY, 4'h9, 2'h0, 32'h00004000, 32'h00000100, 1'h1);
    chk(32'(res), 32'h1);
    chk(32'(tr.is_irq), 32'h1);
    chk(tr.epc, 32'h00000100);
    apb(1'h1, 12'h000, 32'h0);
    run(SFPS_FRAME_DESTROY, 4'h9, 2'h0, 32'h00004000, 32'h00000100, 1'h1);
    chk(32'(res) + 32'(hold_seen), 32'h3);
    irq_pending <= 1'h0;
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      err_addr <= (i == 0 ? 32'h00002020 : 32'h00002000) - 32'h8;
      for (int j = 0; j < 2; j++) begin
        run(i == 0 ? SFPS_FRAME_DESTROY_RETURN_ZERO : SFPS_FRAME_CREATE, 4'h8, 2'h0,
            32'h00002000, 32'h00000200, 1'h1);
        if (j == 0) chk(tr.tval, top - 32'h8);
        if (j == 0) chk(tr.cause, i == 0 ? 32'h5 : 32'h7);
        chk(32'(res), j == 0 ? 32'h1 : 32'h2);
        @(posedge pclk);
        err_addr <= 32'h00000001;
      end
    end
    apb(1'h1, 12'h000, 32'h2);
    err_addr <= 32'h00002FFC;
    run(SFPS_FRAME_CREATE, 4'h7, 2'h1, 32'h00003000, 32'h00000300, 1'h1);
    chk(32'(res), 32'h2);
    chk(32'(imp_seen), 32'h1);
    apb(1'h0, 12'h004, 32'h0);
    chk(rdv, 32'h2);
    apb(1'h1, 12'h004, 32'h2);
    apb(1'h0, 12'h004, 32'h0);
    chk(rdv, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    chk(rdv, 32'h7);
    apb(1'h0, 12'h00C, 32'h0);
    chk(rdv, 32'(ndone));
    complete_run();
  end
endmodule : test_stack_frame_push_pop_sequencer
